// ==== logic/bar_pkg.sv ====
// constants shared by the buffer/accumulator register bank
// assumes a 32-bit ahb-lite bus, one word per register
// Behaviour
// [RQ1] mode field codes: 000 stop, 001 start (default), 100 pre-alert, 110 post-alert
// [RQ2] host never writes mode codes 010, 011, 101 or 111
// [RQ3] format 00 or 11: word is 12-bit result then four zero bits
// [RQ4] format 01: result then 3-bit channel tag, 000 chan0, 001 chan1
// [RQ5] format 10: result, channel tag, then valid flag in last bit
// [RQ6] buffered words are 16 bits, layout chosen by 2-bit format, reset 00
// [RQ7] read-only 5-bit fill count reports filled entries, zero to sixteen
// [RQ8] fill count, sums and progress clear at reset, general call, sequence start
// [RQ9] summing enable code 0000 off (reset), only 1111 turns summing on
// [RQ10] host never writes summing enable codes 0001 through 1110
// [RQ11] each channel sum readable as low and high read-only bytes, reset zero
// [RQ12] read-only 4-bit progress in bits 3..0 counts completed accumulations
// [RQ13] reserved bits are read-only and always read zero
// [RQ14] channel sum is a 16-bit value, high byte above low byte
package bar_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_FILL = 8'h01;
    localparam logic [7:0] IDX_PROG = 8'h02;
    localparam logic [7:0] IDX_C0_LO = 8'h08;
    localparam logic [7:0] IDX_C0_HI = 8'h09;
    localparam logic [7:0] IDX_C1_LO = 8'h0a;
    localparam logic [7:0] IDX_C1_HI = 8'h0b;
    localparam logic [7:0] IDX_FMT = 8'h28;
    localparam logic [7:0] IDX_MODE = 8'h2c;
    localparam logic [7:0] IDX_SUMEN = 8'h30;
    localparam logic [7:0] IDX_SEQ = 8'h3f;
    localparam int ADDR_LSB = 2;
    localparam int IDX_W = 8;

    // field widths
    localparam int MODE_W = 3;
    localparam int FMT_W = 2;
    localparam int FILL_W = 5;
    localparam int PROG_W = 4;
    localparam int SUMEN_W = 4;
    localparam int RES_W = 12;
    localparam int TAG_W = 3;
    localparam int WORD_W = 16;
    localparam int SUM_W = 16;
    localparam int SEQ_GO_POS = 0;

    // reset values
    localparam logic [MODE_W-1:0] MODE_RST = 3'h1;
    localparam logic [FMT_W-1:0] FMT_RST = 2'h0;
    localparam logic [SUMEN_W-1:0] SUMEN_RST = 4'h0;
    localparam logic [FILL_W-1:0] FILL_RST = 5'h00;
    localparam logic [PROG_W-1:0] PROG_RST = 4'h0;
    localparam logic [SUM_W-1:0] SUM_RST = 16'h0000;

    // mode codes
    localparam logic [MODE_W-1:0] MODE_STOP = 3'h0;
    localparam logic [MODE_W-1:0] MODE_START = 3'h1;
    localparam logic [MODE_W-1:0] MODE_PRE = 3'h4;
    localparam logic [MODE_W-1:0] MODE_POST = 3'h6;

    // word layouts
    localparam logic [FMT_W-1:0] FMT_PLAIN = 2'h0;
    localparam logic [FMT_W-1:0] FMT_TAG = 2'h1;
    localparam logic [FMT_W-1:0] FMT_TAG_VALID = 2'h2;
    localparam logic [FMT_W-1:0] FMT_PLAIN_ALT = 2'h3;

    localparam logic [SUMEN_W-1:0] SUMEN_ON = 4'hf;
    localparam logic [FILL_W-1:0] FILL_MAX = 5'h10;

    // ahb constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage

// ==== logic/bar_chan_sum.sv ====
// one channel's summing register
// assumes clear and add pulses from the same clock domain
`timescale 1ns/10ps
module bar_chan_sum
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clear,
    input wire logic add_en,
    input wire logic [bar_pkg::RES_W-1:0] addend,
    output logic [bar_pkg::SUM_W-1:0] sum_q
);
    import bar_pkg::*;

    // ------------------------------------------------------------
    // running sum
    // ------------------------------------------------------------
    // [RQ8] sum cleared
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sum_q <= SUM_RST;
        else if (clear)
            sum_q <= SUM_RST;
        else if (add_en)
            sum_q <= sum_q + {{(SUM_W-RES_W){1'b0}}, addend};
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // [RQ8] clear empties sum
    sum_clear_a: assert property ( // [RQ8]
        @(posedge hclk) disable iff (!hresetn)
        clear |=> sum_q == SUM_RST)
        else $error("channel sum not cleared");

    // [RQ14] sum adds addend
    sum_add_a: assert property ( // [RQ14]
        @(posedge hclk) disable iff (!hresetn)
        (add_en && !clear) |=>
        sum_q == $past(sum_q) + {{(SUM_W-RES_W){1'b0}}, $past(addend)})
        else $error("channel sum did not add sample");
endmodule

// ==== logic/bar_regs.sv ====
// buffer and accumulator register bank behind an ahb-lite slave
// assumes conversion events and general-call reset come from hclk logic
`timescale 1ns/10ps
module bar_regs
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic gen_call_reset,
    input wire logic conv_done,
    input wire logic [bar_pkg::RES_W-1:0] conv_result,
    input wire logic conv_chan,
    input wire logic conv_valid,
    output logic [bar_pkg::WORD_W-1:0] buf_word,
    output logic buf_word_we,
    output logic [bar_pkg::MODE_W-1:0] buffer_mode_code,
    output logic summing_on
);
    import bar_pkg::*;

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    logic addr_ok;
    logic [IDX_W-1:0] addr_idx;
    logic wr_pend_q;
    logic [IDX_W-1:0] wr_idx_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic seq_go;
    logic clr_all;

    logic [FMT_W-1:0] fmt_q;
    logic [MODE_W-1:0] mode_q;
    logic [SUMEN_W-1:0] sumen_q;
    logic [FILL_W-1:0] fill_count_q;
    logic [PROG_W-1:0] summing_progress_q;
    logic [SUM_W-1:0] chan0_sum;
    logic [SUM_W-1:0] chan1_sum;
    logic [WORD_W-1:0] word_d;
    logic [WORD_W-1:0] word_q;
    logic word_we_q;
    logic sum_on_q;
    logic add0;
    logic add1;

    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
    assign addr_idx = haddr[ADDR_LSB +: IDX_W];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= '0;
        end
        else
        begin
            wr_pend_q <= addr_ok && hwrite;
            wr_idx_q <= addr_idx;
        end
    end

    // ------------------------------------------------------------
    // writable control registers
    // ------------------------------------------------------------
    // [RQ6] layout select stored
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fmt_q <= FMT_RST;
        else if (wr_pend_q && wr_idx_q == IDX_FMT)
            fmt_q <= hwdata[FMT_W-1:0];
    end

    // [RQ1] mode code stored
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mode_q <= MODE_RST;
        else if (wr_pend_q && wr_idx_q == IDX_MODE)
            mode_q <= hwdata[MODE_W-1:0];
    end

    // [RQ9] summing enable stored
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sumen_q <= SUMEN_RST;
        else if (wr_pend_q && wr_idx_q == IDX_SUMEN)
            sumen_q <= hwdata[SUMEN_W-1:0];
    end

    // [RQ8] sequence start pulse
    assign seq_go = wr_pend_q && wr_idx_q == IDX_SEQ && hwdata[SEQ_GO_POS];
    assign clr_all = seq_go || gen_call_reset;

    // ------------------------------------------------------------
    // buffered word forming
    // ------------------------------------------------------------
    always_comb
    begin
        word_d = {conv_result, 4'h0};
        if (fmt_q == FMT_TAG)
            // [RQ4] channel tag
            word_d = {conv_result, {(TAG_W-1){1'b0}}, conv_chan, 1'b0};
        else if (fmt_q == FMT_TAG_VALID)
            // [RQ5] tag and valid flag
            word_d = {conv_result, {(TAG_W-1){1'b0}}, conv_chan, conv_valid};
    end

    // [RQ3] plain layout default
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            word_q <= '0;
            word_we_q <= 1'b0;
        end
        else
        begin
            word_we_q <= conv_done && mode_q != MODE_STOP;
            if (conv_done)
                word_q <= word_d;
        end
    end

    // ------------------------------------------------------------
    // fill count and summing progress
    // ------------------------------------------------------------
    // [RQ7] fill count saturates
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fill_count_q <= FILL_RST;
        else if (clr_all)
            fill_count_q <= FILL_RST;
        else if (conv_done && mode_q != MODE_STOP && fill_count_q != FILL_MAX)
            fill_count_q <= fill_count_q + 5'h01;
    end

    // [RQ9] only full code enables
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            sum_on_q <= 1'b0;
        else
            sum_on_q <= (sumen_q == SUMEN_ON);
    end

    assign add0 = conv_done && (sumen_q == SUMEN_ON) && !conv_chan;
    assign add1 = conv_done && (sumen_q == SUMEN_ON) && conv_chan;

    // [RQ12] completed accumulations
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            summing_progress_q <= PROG_RST;
        else if (clr_all)
            summing_progress_q <= PROG_RST;
        else if (add0 || add1)
            summing_progress_q <= summing_progress_q + 4'h1;
    end

    bar_chan_sum u_sum0
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(clr_all),
        .add_en(add0),
        .addend(conv_result),
        .sum_q(chan0_sum)
    );

    bar_chan_sum u_sum1
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(clr_all),
        .add_en(add1),
        .addend(conv_result),
        .sum_q(chan1_sum)
    );

    // ------------------------------------------------------------
    // read mux, registered at the address phase
    // ------------------------------------------------------------
    // [RQ13] reserved bits zero
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (addr_idx == IDX_FILL)
            rdata_d[FILL_W-1:0] = fill_count_q;
        else if (addr_idx == IDX_PROG)
            rdata_d[PROG_W-1:0] = summing_progress_q;
        // [RQ11] [RQ14] sum byte reads
        else if (addr_idx == IDX_C0_LO)
            rdata_d[7:0] = chan0_sum[7:0];
        else if (addr_idx == IDX_C0_HI)
            rdata_d[7:0] = chan0_sum[15:8];
        else if (addr_idx == IDX_C1_LO)
            rdata_d[7:0] = chan1_sum[7:0];
        else if (addr_idx == IDX_C1_HI)
            rdata_d[7:0] = chan1_sum[15:8];
        else if (addr_idx == IDX_FMT)
            rdata_d[FMT_W-1:0] = fmt_q;
        else if (addr_idx == IDX_MODE)
            rdata_d[MODE_W-1:0] = mode_q;
        else if (addr_idx == IDX_SUMEN)
            rdata_d[SUMEN_W-1:0] = sumen_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= 32'h0000_0000;
        else if (addr_ok && !hwrite)
            rdata_q <= rdata_d;
    end

    // zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    assign hrdata = rdata_q;
    assign buf_word = word_q;
    assign buf_word_we = word_we_q;
    assign buffer_mode_code = mode_q;
    assign summing_on = sum_on_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence wr_addr_s(logic [IDX_W-1:0] idx);
        addr_ok && hwrite && addr_idx == idx;
    endsequence

    sequence rd_addr_s(logic [IDX_W-1:0] idx);
        addr_ok && !hwrite && addr_idx == idx;
    endsequence

    mode_write_a: assert property ( // [RQ1]
        @(posedge hclk) disable iff (!hresetn)
        wr_addr_s(IDX_MODE) ##1 1'b1 |=> buffer_mode_code == $past(hwdata[MODE_W-1:0]))
        else $error("mode code not taken from write");

    plain_word_a: assert property ( // [RQ3]
        @(posedge hclk) disable iff (!hresetn)
        (conv_done && (fmt_q == FMT_PLAIN || fmt_q == FMT_PLAIN_ALT)) |=>
        buf_word == {$past(conv_result), 4'h0})
        else $error("plain word layout wrong");

    tag_word_a: assert property ( // [RQ4]
        @(posedge hclk) disable iff (!hresetn)
        (conv_done && fmt_q == FMT_TAG) |=>
        buf_word[3:0] == {2'b00, $past(conv_chan), 1'b0}
        && buf_word[15:4] == $past(conv_result))
        else $error("tagged word layout wrong");

    valid_word_a: assert property ( // [RQ5]
        @(posedge hclk) disable iff (!hresetn)
        (conv_done && fmt_q == FMT_TAG_VALID) |=>
        buf_word[3:0] == {2'b00, $past(conv_chan), $past(conv_valid)})
        else $error("valid flag layout wrong");

    fill_bound_a: assert property ( // [RQ7]
        @(posedge hclk) disable iff (!hresetn)
        (fill_count_q < FILL_MAX && conv_done && mode_q != MODE_STOP && !clr_all)
        |=> fill_count_q == $past(fill_count_q) + 5'h01 && fill_count_q <= FILL_MAX)
        else $error("fill count step or bound wrong");

    seq_clear_a: assert property ( // [RQ8]
        @(posedge hclk) disable iff (!hresetn)
        clr_all |=> fill_count_q == FILL_RST && summing_progress_q == PROG_RST)
        else $error("status not cleared on sequence start");

    summing_off_a: assert property ( // [RQ9]
        @(posedge hclk) disable iff (!hresetn)
        (sumen_q != SUMEN_ON && !clr_all) |=> $stable(chan0_sum) && $stable(chan1_sum))
        else $error("summing while disabled");

    high_byte_a: assert property ( // [RQ11]
        @(posedge hclk) disable iff (!hresetn)
        rd_addr_s(IDX_C1_HI) |=> hrdata == {24'h00_0000, $past(chan1_sum[15:8])})
        else $error("high byte read wrong");

    progress_step_a: assert property ( // [RQ12]
        @(posedge hclk) disable iff (!hresetn)
        ((add0 || add1) && !clr_all) |=> summing_progress_q == $past(summing_progress_q) + 4'h1)
        else $error("progress count did not step");

    reserved_zero_a: assert property ( // [RQ13]
        @(posedge hclk) disable iff (!hresetn)
        rd_addr_s(IDX_FILL) |=> hrdata[31:FILL_W] == '0)
        else $error("reserved bits not zero");

    stop_strobe_a: assert property ( // [RQ1]
        @(posedge hclk) disable iff (!hresetn)
        conv_done |=> buf_word_we == ($past(mode_q) != MODE_STOP))
        else $error("word strobe does not follow mode");

    no_conv_strobe_a: assert property ( // [RQ1]
        @(posedge hclk) disable iff (!hresetn)
        !conv_done |=> !buf_word_we)
        else $error("word strobe without conversion");

    fill_hold_a: assert property ( // [RQ7]
        @(posedge hclk) disable iff (!hresetn)
        (fill_count_q == FILL_MAX && !clr_all) |=> fill_count_q == FILL_MAX)
        else $error("fill count left its ceiling");

    summing_flag_a: assert property ( // [RQ9]
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> summing_on == $past(sumen_q == SUMEN_ON))
        else $error("summing flag does not follow enable");

    low_byte_a: assert property ( // [RQ11]
        @(posedge hclk) disable iff (!hresetn)
        rd_addr_s(IDX_C0_LO) |=> hrdata == {24'h00_0000, $past(chan0_sum[7:0])})
        else $error("low byte read wrong");

    mode_reserved_a: assert property ( // [RQ13]
        @(posedge hclk) disable iff (!hresetn)
        rd_addr_s(IDX_MODE) |=> hrdata[31:MODE_W] == '0)
        else $error("mode reserved bits not zero");
endmodule

// ==== tb/bar_host.sv ====
// ahb-lite host model for the register bank
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/10ps
module bar_host
(
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic hung
);
    import bar_pkg::*;
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        hung = 1'b0;
    end
    // bounded wait for hready at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 64)
        begin
            @(posedge hclk);
            n++;
        end
        if (hready !== 1'b1)
            hung <= 1'b1;
    endtask
    // one single word transfer; entered right after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= 32'(idx) << ADDR_LSB;
        hwrite <= wr;
        hwdata <= ~hwdata;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~haddr;
        hwdata <= wr ? wd : ~wd;
        wait_ready();
        rd = hrdata;
    endtask
endmodule

// ==== tb/buffer_accumulator_regs_tb_top.sv ====
// self-checking bench for the buffer/accumulator register bank
// assumes bar_host drives the bus; integer model predicts results
`timescale 1ns/10ps
module buffer_accumulator_regs_tb_top;
    import bar_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, hung;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic gen_call_reset = 1'b0, conv_done = 1'b0, conv_chan = 1'b0, conv_valid = 1'b0;
    logic [RES_W-1:0] conv_result = 12'h000;
    logic [WORD_W-1:0] buf_word;
    logic buf_word_we, summing_on;
    logic [MODE_W-1:0] buffer_mode_code;
    int bad_count = 0, n_tests = 0;
    int m_fill, m_prog, m_fmt, m_mode, m_en;
    int m_sum [2];
    // legal codes only
    int modes [4] = '{0, 1, 4, 6};
    always #5 hclk = ~hclk;
    bar_host host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hung(hung));
    bar_regs dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .gen_call_reset(gen_call_reset), .conv_done(conv_done), .conv_result(conv_result),
        .conv_chan(conv_chan), .conv_valid(conv_valid), .buf_word(buf_word),
        .buf_word_we(buf_word_we), .buffer_mode_code(buffer_mode_code),
        .summing_on(summing_on));
    // ----------------------------------------
    // checking and reporting
    // ----------------------------------------
    task automatic wrap_up();
        $display("counts: %0d compared, %0d mismatched", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    always @(posedge hclk)
        if (hung === 1'b1)
        begin
            bad_count++;
            wrap_up();
        end
    // ----------------------------------------
    // model and bus helpers
    // ----------------------------------------
    task automatic m_clear();
        m_fill = 0;
        m_prog = 0;
        m_sum[0] = 0;
        m_sum[1] = 0;
    endtask
    task automatic m_init();
        m_fmt = 0;
        m_mode = 1;
        m_en = 0;
        m_clear();
    endtask
    task automatic wr(logic [7:0] idx, logic [31:0] d);
        host_u.xfer(1'b1, idx, d, rv);
    endtask
    task automatic rc(string what, logic [7:0] idx, int exp);
        host_u.xfer(1'b0, idx, 32'h0000_0000, rv);
        chk(what, 32'(exp), rv);
    endtask
    task automatic cfg_check();
        rc("format", IDX_FMT, m_fmt);
        rc("mode", IDX_MODE, m_mode);
        rc("enable", IDX_SUMEN, m_en);
        chk("mode port", 32'(m_mode), 32'(buffer_mode_code));
        chk("summing port", 32'(m_en == 15), 32'(summing_on));
    endtask
    task automatic status();
        rc("fill", IDX_FILL, m_fill);
        rc("progress", IDX_PROG, m_prog);
        rc("c0 low", IDX_C0_LO, m_sum[0] % 256);
        rc("c0 high", IDX_C0_HI, m_sum[0] / 256);
        rc("c1 low", IDX_C1_LO, m_sum[1] % 256);
        rc("c1 high", IDX_C1_HI, m_sum[1] / 256);
    endtask
    task automatic conv();
        int res, ch, v, w;
        res = $urandom % 4096;
        ch = $urandom % 2;
        v = $urandom % 2;
        conv_done <= 1'b1;
        conv_result <= RES_W'(res);
        conv_chan <= ch[0];
        conv_valid <= v[0];
        @(posedge hclk);
        conv_done <= 1'b0;
        w = res * 16 + ((m_fmt == 1 || m_fmt == 2) ? ch * 2 : 0) + (m_fmt == 2 ? v : 0);
        if (m_mode != 0 && m_fill < 16)
            m_fill++;
        if (m_en == 15)
        begin
            m_sum[ch] = (m_sum[ch] + res) % 65536;
            m_prog = (m_prog + 1) % 16;
        end
        #1;
        chk("word strobe", 32'(m_mode != 0), 32'(buf_word_we));
        if (m_mode != 0)
            chk("word", 32'(w), 32'(buf_word));
        @(posedge hclk);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rv = $urandom(20);
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        m_init();
        cfg_check();
        status();
        rc("unmapped", 8'h05, 0);
        rc("sequence", IDX_SEQ, 0);
        chk("response", 32'(HRESP_OKAY), 32'(hresp));
        $display("test reset values done");
        wr(IDX_FMT, 32'hffff_ffff);
        wr(IDX_MODE, 32'hffff_fffe);
        wr(IDX_SUMEN, 32'hffff_ffff);
        wr(IDX_FILL, 32'hffff_ffff);
        wr(8'h05, 32'hffff_ffff);
        m_fmt = 3;
        m_mode = 6;
        m_en = 15;
        cfg_check();
        status();
        $display("test reserved bits done");
        foreach (modes[i])
        begin
            for (int f = 0; f < 4; f++)
            begin
                m_mode = modes[i];
                m_fmt = f;
                m_en = f[0] ? 15 : 0;
                wr(IDX_MODE, 32'(m_mode));
                wr(IDX_FMT, 32'(m_fmt));
                wr(IDX_SUMEN, 32'(m_en));
                cfg_check();
                repeat (3) conv();
            end
            status();
        end
        $display("test modes and formats done");
        wr(IDX_SEQ, 32'h0000_0001);
        m_clear();
        status();
        repeat (4) conv();
        status();
        gen_call_reset <= 1'b1;
        @(posedge hclk);
        gen_call_reset <= 1'b0;
        @(posedge hclk);
        m_clear();
        status();
        $display("test clears done");
        repeat (3) conv();
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        m_init();
        cfg_check();
        status();
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule
